/* File: verilog/flc_pkg.sv */
/*
  Constants for the four-level limit comparator: register map, field
  positions, reset values, mode codes, indicator colours and timing.
  Assumes a 200 MHz AHB-Lite clock and a signed reading input.
*/
// Summary of operation
// - Reject unordered limits on save, flag error
// - Extreme disabled: no extreme outputs, red LEDs
// - Upper outputs: on above, off at limit-hyst
// - Under outputs: on below, off at limit+hyst
// - One shared hysteresis; zero disables it
// - Standard pattern: each output independent
// - Area pattern: upper, under only within bands
// - Pattern code 0 standard, 1 area
// - Modes 0 always, 1 stable, 2 not-zero
// - Modes 3 stable+not-zero, 4 hold, 5 off
// - Upper LED red above extreme, orange between
// - Under LED orange between, red below extreme
// - Pass LED green within under..upper inclusive
// - Evaluate LED follows gate, or always lit
// - Hold LEDs: green set, red hold, orange block
// - Sample LED: green set, red operating
// - Lock LEDs orange when lock set
// - Stable: within band of 100 ms-old reading
// - Near-zero qualifier from configurable range
package flc_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HYST = 8'h04;
  localparam logic [7:0] OFS_UPPER_UPPER = 8'h08;
  localparam logic [7:0] OFS_UPPER = 8'h0c;
  localparam logic [7:0] OFS_UNDER = 8'h10;
  localparam logic [7:0] OFS_DEEP_UNDER = 8'h14;
  localparam logic [7:0] OFS_SAVE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_NEAR_ZERO = 8'h20;
  localparam logic [7:0] OFS_MOTION_BAND = 8'h24;
  localparam logic [7:0] OFS_MOTION_TIME = 8'h28;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_PAT_BIT = 1;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_BLK_BIT = 8;
  localparam int CTRL_CAL_BIT = 9;
  localparam int CTRL_SET_BIT = 10;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_STABLE_BIT = 1;
  localparam int STAT_NZ_BIT = 2;
  localparam int STAT_OUT_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] HYST_RESET = 32'h0000_0000;
  localparam logic [31:0] UPPER_UPPER_RESET = 32'h0000_0004;
  localparam logic [31:0] UPPER_RESET = 32'h0000_0003;
  localparam logic [31:0] UNDER_RESET = 32'h0000_0002;
  localparam logic [31:0] DEEP_UNDER_RESET = 32'h0000_0001;
  localparam logic [31:0] NEAR_ZERO_RESET = 32'h0000_0000;
  localparam logic [31:0] MOTION_BAND_RESET = 32'h0000_0000;
  localparam logic [31:0] MOTION_TIME_RESET = 32'h0000_0000;
  localparam logic PAT_STANDARD = 1'b0;
  localparam logic PAT_AREA = 1'b1;
  typedef enum logic [2:0] {
    CMP_ALWAYS = 3'b000, CMP_STABLE = 3'b001, CMP_EXCEPT_NEAR_ZERO = 3'b010,
    CMP_STABLE_NOT_NEAR_ZERO = 3'b011, CMP_IN_HOLD = 3'b100, CMP_OFF = 3'b101
  } flc_mode_e;
  typedef enum logic [2:0] {
    HOLD_NONE = 3'b000, HOLD_SAMPLE = 3'b001, HOLD_PEAK = 3'b010,
    HOLD_BOTTOM = 3'b011, HOLD_P2P = 3'b100
  } flc_hold_e;
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED = 2'h2;
  localparam logic [1:0] LED_ORANGE = 2'h3;
  localparam int CLK_MHZ = 200;
  localparam int REF_PERIOD_MS = 100;
  localparam int MS_CYCLES = CLK_MHZ * 1000;
  localparam int REF_PERIOD_CYCLES = REF_PERIOD_MS * MS_CYCLES;
endpackage : flc_pkg

/* File: verilog/flc_top.sv */
/*
  Four-level limit comparator with hysteresis, output patterns, a
  comparison gate from stability, near-zero and hold qualifiers, and
  status indicator drive. Registers sit on an AHB-Lite slave.
  Assumes the reading and control inputs are synchronous to hclk.
*/
`timescale 1ns/100ps
module flc_top import flc_pkg::*; #(
  parameter int RW = 20,
  parameter int MS_CNT = MS_CYCLES,
  parameter int REF_CNT = REF_PERIOD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic signed [RW-1:0] reading,
  input wire logic reading_valid,
  input wire logic evaluate_gate_input,
  input wire logic [2:0] hold_mode_setting,
  input wire logic hold_active,
  input wire logic hold_block_active,
  output logic upper_upper_out,
  output logic upper_out,
  output logic under_out,
  output logic deep_under_out,
  output logic pass_out,
  output logic [1:0] upper_led,
  output logic [1:0] pass_led,
  output logic [1:0] under_led,
  output logic [1:0] eval_led,
  output logic [1:0] peak_led,
  output logic [1:0] bottom_led,
  output logic [1:0] p2p_led,
  output logic [1:0] sample_led,
  output logic [1:0] cal_led,
  output logic [1:0] set_led
);
  localparam int AW = RW + 2;
  localparam int MCW = $clog2(MS_CNT + 1);
  localparam int RCW = $clog2(REF_CNT + 1);

  function automatic logic signed [AW-1:0] sx(input logic [31:0] v);
    sx = AW'(signed'(v[RW-1:0]));
  endfunction : sx

  function automatic logic [AW-1:0] absdiff(input logic signed [AW-1:0] a,
                                            input logic signed [AW-1:0] b);
    absdiff = (a > b) ? AW'(a - b) : AW'(b - a);
  endfunction : absdiff

  function automatic logic [1:0] hold_led(input logic [2:0] sel, input flc_hold_e kind,
                                          input logic act, input logic blk);
    if (sel != kind) hold_led = LED_OFF;
    else if (!act) hold_led = LED_GREEN;
    else if (blk && kind != HOLD_SAMPLE) hold_led = LED_ORANGE;
    else hold_led = LED_RED;
  endfunction : hold_led

  // Bus address phase
  logic [7:0] addr_r;
  logic wr_r;
  logic rd_r;
  logic [31:0] ctrl_r, hyst_r, uu_r, up_r, un_r, du_r, nz_r, mband_r, mtime_r;
  logic [31:0] uu_stg_r, up_stg_r, un_stg_r, du_stg_r;
  logic err_r;
  wire take = hsel && htrans[1] && hready;
  wire wr_save = wr_r && addr_r == OFS_SAVE && hwdata[0];
  wire wr_stat = wr_r && addr_r == OFS_STATUS;
  wire signed [AW-1:0] s_uu = sx(uu_stg_r);
  wire signed [AW-1:0] s_up = sx(up_stg_r);
  wire signed [AW-1:0] s_un = sx(un_stg_r);
  wire signed [AW-1:0] s_du = sx(du_stg_r);
  wire order_ok = (s_du < s_un) && (s_un < s_up) && (s_up < s_uu);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      addr_r <= haddr[7:0];
      wr_r <= take && hwrite;
      rd_r <= take && !hwrite;
    end
  end

  // Settings registers; limits take effect only through a checked save
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
      hyst_r <= HYST_RESET;
      nz_r <= NEAR_ZERO_RESET;
      mband_r <= MOTION_BAND_RESET;
      mtime_r <= MOTION_TIME_RESET;
      uu_stg_r <= UPPER_UPPER_RESET;
      up_stg_r <= UPPER_RESET;
      un_stg_r <= UNDER_RESET;
      du_stg_r <= DEEP_UNDER_RESET;
    end else if (wr_r) begin
      case (addr_r)
        OFS_CTRL: ctrl_r <= hwdata & 32'h0000_0773;
        OFS_HYST: hyst_r <= {{(32-RW){1'b0}}, hwdata[RW-1:0]};
        OFS_UPPER_UPPER: uu_stg_r <= {{(32-RW){1'b0}}, hwdata[RW-1:0]};
        OFS_UPPER: up_stg_r <= {{(32-RW){1'b0}}, hwdata[RW-1:0]};
        OFS_UNDER: un_stg_r <= {{(32-RW){1'b0}}, hwdata[RW-1:0]};
        OFS_DEEP_UNDER: du_stg_r <= {{(32-RW){1'b0}}, hwdata[RW-1:0]};
        OFS_NEAR_ZERO: nz_r <= {{(32-RW){1'b0}}, hwdata[RW-1:0]};
        OFS_MOTION_BAND: mband_r <= {{(32-RW){1'b0}}, hwdata[RW-1:0]};
        OFS_MOTION_TIME: mtime_r <= {16'h0000, hwdata[15:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uu_r <= UPPER_UPPER_RESET;
      up_r <= UPPER_RESET;
      un_r <= UNDER_RESET;
      du_r <= DEEP_UNDER_RESET;
      err_r <= 1'b0;
    end else begin
      if (wr_save && order_ok) begin
        uu_r <= uu_stg_r;
        up_r <= up_stg_r;
        un_r <= un_stg_r;
        du_r <= du_stg_r;
      end
      // A failed save in the clearing cycle keeps the flag set
      if (wr_save && !order_ok) err_r <= 1'b1;
      else if (wr_stat && hwdata[STAT_ERR_BIT]) err_r <= 1'b0;
    end
  end

  wire ext_en = ctrl_r[CTRL_EXT_BIT];
  wire pattern = ctrl_r[CTRL_PAT_BIT];
  wire [2:0] mode = ctrl_r[CTRL_MODE_LSB +: 3];
  wire blk_en = ctrl_r[CTRL_BLK_BIT];
  wire signed [AW-1:0] rd_x = AW'(reading);
  wire signed [AW-1:0] hy = sx(hyst_r);
  wire signed [AW-1:0] l_uu = sx(uu_r);
  wire signed [AW-1:0] l_up = sx(up_r);
  wire signed [AW-1:0] l_un = sx(un_r);
  wire signed [AW-1:0] l_du = sx(du_r);

  // Stability against the reading of one reference period ago
  logic [RCW-1:0] ref_cnt_r;
  logic [MCW-1:0] ms_cnt_r;
  logic [15:0] still_ms_r;
  logic signed [AW-1:0] ref_rd_r;
  logic stable_r;
  wire ref_tick = ref_cnt_r == RCW'(REF_CNT - 1);
  wire ms_tick = ms_cnt_r == MCW'(MS_CNT - 1);
  wire in_band = absdiff(rd_x, ref_rd_r) <= AW'(mband_r[RW-1:0]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_r <= '0;
      ms_cnt_r <= '0;
      still_ms_r <= 16'h0000;
      ref_rd_r <= '0;
      stable_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_tick ? '0 : ref_cnt_r + 1'b1;
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
      if (ref_tick) ref_rd_r <= rd_x;
      if (!in_band) still_ms_r <= 16'h0000;
      else if (ms_tick && still_ms_r != 16'hffff) still_ms_r <= still_ms_r + 16'h0001;
      stable_r <= in_band && (still_ms_r > mtime_r[15:0]);
    end
  end

  wire near_zero = absdiff(rd_x, '0) <= AW'(nz_r[RW-1:0]);

  logic gate;
  always_comb begin
    case (mode)
      CMP_ALWAYS: gate = 1'b1;
      CMP_STABLE: gate = stable_r;
      CMP_EXCEPT_NEAR_ZERO: gate = !near_zero;
      CMP_STABLE_NOT_NEAR_ZERO: gate = stable_r && !near_zero;
      CMP_IN_HOLD: gate = hold_active;
      default: gate = 1'b0;
    endcase
  end

  logic uu_st_r, up_st_r, un_st_r, du_st_r;
  // Upper set above limit, clear at limit minus hysteresis
  // One hysteresis, zero gives plain compare
  wire uu_nxt = (rd_x > l_uu) || (uu_st_r && rd_x > l_uu - hy);
  wire up_nxt = (rd_x > l_up) || (up_st_r && rd_x > l_up - hy);
  // Under set below limit, clear at limit plus hysteresis
  wire un_nxt = (rd_x < l_un) || (un_st_r && rd_x < l_un + hy);
  wire du_nxt = (rd_x < l_du) || (du_st_r && rd_x < l_du + hy);
  wire smp = reading_valid && gate;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {uu_st_r, up_st_r, un_st_r, du_st_r} <= 4'h0;
    end else if (!gate) begin
      {uu_st_r, up_st_r, un_st_r, du_st_r} <= 4'h0;
    end else if (smp) begin
      {uu_st_r, up_st_r, un_st_r, du_st_r} <= {uu_nxt, up_nxt, un_nxt, du_nxt};
    end
  end

  wire area = pattern == PAT_AREA;
  wire uu_o = ext_en && uu_st_r;
  wire du_o = ext_en && du_st_r;
  // Area: upper and under within their bands
  wire up_o = up_st_r && !(area && uu_st_r);
  wire un_o = un_st_r && !(area && du_st_r);
  // Pass between under and upper inclusive
  wire pass_o = gate && !up_st_r && !un_st_r;
  wire [1:0] upper_led_nxt = !up_st_r ? LED_OFF :
                             (!ext_en || uu_st_r) ? LED_RED : LED_ORANGE;
  wire [1:0] under_led_nxt = !un_st_r ? LED_OFF :
                             (!ext_en || du_st_r) ? LED_RED : LED_ORANGE;
  wire [1:0] eval_led_nxt = (!blk_en || evaluate_gate_input) ? LED_GREEN : LED_OFF;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {upper_upper_out, upper_out, under_out, deep_under_out, pass_out} <= 5'h00;
      upper_led <= LED_OFF;
      pass_led <= LED_OFF;
      under_led <= LED_OFF;
      eval_led <= LED_OFF;
      peak_led <= LED_OFF;
      bottom_led <= LED_OFF;
      p2p_led <= LED_OFF;
      sample_led <= LED_OFF;
      cal_led <= LED_OFF;
      set_led <= LED_OFF;
    end else begin
      {upper_upper_out, upper_out, under_out, deep_under_out, pass_out} <=
        {uu_o, up_o, un_o, du_o, pass_o};
      upper_led <= upper_led_nxt;
      pass_led <= pass_o ? LED_GREEN : LED_OFF;
      under_led <= under_led_nxt;
      eval_led <= eval_led_nxt;
      peak_led <= hold_led(hold_mode_setting, HOLD_PEAK, hold_active, hold_block_active);
      bottom_led <= hold_led(hold_mode_setting, HOLD_BOTTOM, hold_active, hold_block_active);
      p2p_led <= hold_led(hold_mode_setting, HOLD_P2P, hold_active, hold_block_active);
      sample_led <= hold_led(hold_mode_setting, HOLD_SAMPLE, hold_active, 1'b0);
      cal_led <= ctrl_r[CTRL_CAL_BIT] ? LED_ORANGE : LED_OFF;
      set_led <= ctrl_r[CTRL_SET_BIT] ? LED_ORANGE : LED_OFF;
    end
  end

  // Read data registered in the address phase so the answer is zero-wait
  wire [31:0] stat_word = {24'h000000,
    upper_upper_out, upper_out, under_out, deep_under_out,
    pass_out, near_zero, stable_r, err_r};
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      OFS_CTRL: rd_mux = ctrl_r;
      OFS_HYST: rd_mux = hyst_r;
      OFS_UPPER_UPPER: rd_mux = uu_r;
      OFS_UPPER: rd_mux = up_r;
      OFS_UNDER: rd_mux = un_r;
      OFS_DEEP_UNDER: rd_mux = du_r;
      OFS_STATUS: rd_mux = stat_word;
      OFS_NEAR_ZERO: rd_mux = nz_r;
      OFS_MOTION_BAND: rd_mux = mband_r;
      OFS_MOTION_TIME: rd_mux = mtime_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (take && !hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  order_reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_save && !order_ok |=> err_r && $stable(up_r) && $stable(uu_r))
    else $error("unordered save accepted");
  extreme_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ext_en ##1 !$past(ext_en) |-> !upper_upper_out && !deep_under_out)
    else $error("extreme output while disabled");
  upper_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    smp && rd_x > l_up |=> up_st_r ##1 upper_led != LED_OFF)
    else $error("upper not set above limit");
  under_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    smp && rd_x < l_un |=> un_st_r ##1 under_led != LED_OFF)
    else $error("under not set below limit");
  hyst_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    smp && up_st_r && rd_x > l_up - hy |=> up_st_r)
    else $error("upper released inside hysteresis");
  area_band_a: assert property (@(posedge hclk) disable iff (!hresetn)
    area && uu_st_r |=> !upper_out)
    else $error("area upper overlaps extreme");
  gate_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !gate |=> !pass_out ##1 !upper_upper_out && !upper_out && !under_out && !deep_under_out)
    else $error("output while comparison inhibited");
  mode_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == CMP_OFF |=> !uu_st_r && !up_st_r && !un_st_r && !du_st_r)
    else $error("comparison state kept in off mode");
  pass_green_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gate && !up_st_r && !un_st_r |=> pass_out && pass_led == LED_GREEN)
    else $error("pass not shown inside limits");
  under_orange_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_en && un_st_r && !du_st_r |=> under_led == LED_ORANGE)
    else $error("under indicator not orange");
  sample_red_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hold_mode_setting == HOLD_SAMPLE && hold_active |=> sample_led == LED_RED)
    else $error("sample indicator not red");
  eval_led_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !blk_en |=> eval_led == LED_GREEN)
    else $error("evaluate indicator not lit");
  lock_led_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_r[CTRL_CAL_BIT] |=> cal_led == LED_ORANGE)
    else $error("cal lock indicator not orange");
endmodule : flc_top

/* File: test/flc_ahb_src.sv */
/*
  Settings source model: an AHB-Lite master that writes and reads the
  comparator registers one whole word at a time.
  Assumes one slave whose hreadyout is returned as hready.
*/
`timescale 1ns/100ps
module flc_ahb_src (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Entered just after a rising edge; waits out any wait states
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd_reg
endmodule : flc_ahb_src

/* File: test/tb_four_limit_comparator.sv */
/*
  Self-checking bench for the four-level limit comparator: a row table
  of readings and settings, then reset, save, mode and indicator cases.
  Assumes the settings source model drives the register bus.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_four_limit_comparator import flc_pkg::*; ;
  localparam int RW = 20;
  localparam logic [1:0] of = LED_OFF;
  localparam logic [1:0] gr = LED_GREEN;
  localparam logic [1:0] rd = LED_RED;
  localparam logic [1:0] og = LED_ORANGE;
  typedef struct {int r; logic [31:0] ctrl; logic [31:0] hyst; logic [10:0] e;} flc_row_s;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready_w, hresp, reading_valid, evaluate_gate_input;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, upper_led, pass_led, under_led, eval_led, hled;
  logic [1:0] peak_led, bottom_led, p2p_led, sample_led, cal_led, set_led;
  logic [2:0] hsize, hold_mode_setting;
  logic signed [RW-1:0] reading;
  logic hold_active, hold_block_active;
  logic upper_upper_out, upper_out, under_out, deep_under_out, pass_out;
  logic [5:0] mexp = 6'b001111;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  wire logic [10:0] obs = {upper_upper_out, upper_out, under_out, deep_under_out, pass_out,
                           upper_led, under_led, pass_led};
  logic [7:0] ra [8] = '{OFS_CTRL, OFS_HYST, OFS_UPPER_UPPER, OFS_UPPER, OFS_UNDER,
                         OFS_DEEP_UNDER, OFS_NEAR_ZERO, 8'h40};
  logic [31:0] rv [8] = '{CTRL_RESET, 32'h0, UPPER_UPPER_RESET, UPPER_RESET, UNDER_RESET,
                          DEEP_UNDER_RESET, NEAR_ZERO_RESET, 32'h0};
  flc_row_s rows [24] = '{
    '{250, 1, 0, {5'b11000, rd, of, of}}, '{150, 1, 0, {5'b01000, og, of, of}},
    '{100, 1, 0, {5'b00001, of, of, gr}}, '{0, 1, 0, {5'b00001, of, of, gr}},
    '{-50, 1, 0, {5'b00100, of, og, of}}, '{-150, 1, 0, {5'b00110, of, rd, of}},
    '{250, 3, 0, {5'b10000, rd, of, of}}, '{150, 3, 0, {5'b01000, og, of, of}},
    '{-50, 3, 0, {5'b00100, of, og, of}}, '{-150, 3, 0, {5'b00010, of, rd, of}},
    '{250, 0, 0, {5'b01000, rd, of, of}}, '{-150, 0, 0, {5'b00100, of, rd, of}},
    '{150, 1, 10, {5'b01000, og, of, of}}, '{95, 1, 10, {5'b01000, og, of, of}},
    '{90, 1, 10, {5'b00001, of, of, gr}}, '{-5, 1, 10, {5'b00100, of, og, of}},
    '{9, 1, 10, {5'b00100, of, og, of}}, '{10, 1, 10, {5'b00001, of, of, gr}},
    '{250, 1, 10, {5'b11000, rd, of, of}}, '{195, 1, 10, {5'b11000, rd, of, of}},
    '{190, 1, 10, {5'b01000, og, of, of}}, '{-150, 1, 10, {5'b00110, of, rd, of}},
    '{-95, 1, 10, {5'b00110, of, rd, of}}, '{-90, 1, 10, {5'b00100, of, og, of}}};

  flc_ahb_src src (.hclk(hclk), .hready(hready_w), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  flc_top #(.RW(RW), .MS_CNT(4), .REF_CNT(40)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready_w), .hreadyout(hready_w), .hrdata(hrdata),
    .hresp(hresp), .reading(reading), .reading_valid(reading_valid),
    .evaluate_gate_input(evaluate_gate_input), .hold_mode_setting(hold_mode_setting),
    .hold_active(hold_active), .hold_block_active(hold_block_active),
    .upper_upper_out(upper_upper_out), .upper_out(upper_out), .under_out(under_out),
    .deep_under_out(deep_under_out), .pass_out(pass_out), .upper_led(upper_led),
    .pass_led(pass_led), .under_led(under_led), .eval_led(eval_led), .peak_led(peak_led),
    .bottom_led(bottom_led), .p2p_led(p2p_led), .sample_led(sample_led),
    .cal_led(cal_led), .set_led(set_led));

  always #2.5 hclk = ~hclk;

  // A hang is counted as a mismatch; the whole run needs a few hundred cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic note(input string s);
    $display("test %s finished, mismatches so far %0d", s, n_errors);
  endtask : note

  // One sample pulse, then wait past the two-edge decision latency
  task automatic apply(input int r);
    reading <= r[RW-1:0];
    reading_valid <= 1'b1;
    @(posedge hclk);
    reading_valid <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
  endtask : apply

  initial begin
    hresetn = 1'b0;
    reading = '0;
    reading_valid = 1'b0;
    evaluate_gate_input = 1'b0;
    hold_mode_setting = 3'h0;
    hold_active = 1'b0;
    hold_block_active = 1'b0;
    repeat (5) @(posedge hclk);
    #1;
    `CHK({hready_w, obs}, 12'h800)
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    src.wr_reg(8'h40, 32'h5);
    for (int i = 0; i < 8; i++) begin
      src.rd_reg(ra[i], q);
      `CHK(q, rv[i])
    end
    `CHK(hresp, 1'b0)
    note("reset values");
    src.wr_reg(OFS_UPPER_UPPER, 32'(200));
    src.wr_reg(OFS_UPPER, 32'(100));
    src.wr_reg(OFS_UNDER, 32'(0));
    src.wr_reg(OFS_DEEP_UNDER, 32'(-100));
    src.wr_reg(OFS_SAVE, 32'h1);
    src.rd_reg(OFS_DEEP_UNDER, q);
    `CHK(q, {12'h0, 20'hfff9c})
    for (int i = 0; i < 24; i++) begin
      src.wr_reg(OFS_CTRL, rows[i].ctrl);
      src.wr_reg(OFS_HYST, rows[i].hyst);
      apply(rows[i].r);
      `CHK(obs, rows[i].e)
    end
    note("decision table");
    src.wr_reg(OFS_HYST, 32'h0);
    src.wr_reg(OFS_CTRL, 32'h1);
    repeat (50) apply(50);
    src.rd_reg(OFS_STATUS, q);
    `CHK(q[STAT_STABLE_BIT], 1'b1)
    for (int m = 0; m < 6; m++) begin
      src.wr_reg(OFS_CTRL, 32'h1 | (m << CTRL_MODE_LSB));
      apply(50);
      `CHK(pass_out, mexp[m])
    end
    apply(250);
    `CHK(obs[10:6], 5'h0)
    src.wr_reg(OFS_CTRL, 32'h41);
    hold_active <= 1'b1;
    apply(50);
    `CHK(pass_out, 1'b1)
    hold_active <= 1'b0;
    src.wr_reg(OFS_CTRL, 32'h21);
    apply(0);
    `CHK(pass_out, 1'b0)
    src.wr_reg(OFS_CTRL, 32'h1);
    apply(0);
    `CHK(pass_out, 1'b1)
    note("comparison modes");
    src.wr_reg(OFS_UNDER, 32'(100));
    src.wr_reg(OFS_SAVE, 32'h1);
    src.rd_reg(OFS_STATUS, q);
    `CHK(q[STAT_ERR_BIT], 1'b1)
    src.rd_reg(OFS_UNDER, q);
    `CHK(q, 32'h0)
    src.wr_reg(OFS_STATUS, 32'h1);
    src.rd_reg(OFS_STATUS, q);
    `CHK(q[STAT_ERR_BIT], 1'b0)
    note("save order check");
    src.wr_reg(OFS_CTRL, 32'h701);
    apply(50);
    `CHK({eval_led, cal_led, set_led}, {of, og, og})
    evaluate_gate_input <= 1'b1;
    apply(50);
    `CHK(eval_led, gr)
    src.wr_reg(OFS_CTRL, 32'h1);
    evaluate_gate_input <= 1'b0;
    apply(50);
    `CHK({eval_led, cal_led, set_led}, {gr, of, of})
    for (int h = 1; h <= 4; h++) begin
      for (int s = 0; s < 3; s++) begin
        hold_mode_setting <= 3'(h);
        hold_active <= (s != 0);
        hold_block_active <= (s == 2);
        apply(50);
        hled = (h == 1) ? sample_led : (h == 2) ? peak_led : (h == 3) ? bottom_led : p2p_led;
        `CHK(hled, (s == 0) ? gr : (s == 1 || h == 1) ? rd : og)
      end
    end
    note("indicators");
    // Reset in mid-run must drop outputs and restore the upper limit and the control register
    src.wr_reg(OFS_CTRL, 32'h703);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    `CHK(obs, 11'h0)
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    src.rd_reg(OFS_UPPER, q);
    `CHK(q, UPPER_RESET)
    src.rd_reg(OFS_CTRL, q);
    `CHK(q, CTRL_RESET)
    `CHK({eval_led, cal_led, set_led}, {gr, of, of})
    note("mid-run reset");
    results();
  end
endmodule : tb_four_limit_comparator
